// *** core/sfs_defines.vh ***
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH
// Overview of operation
// R1 - Framed enable turns select pin into frame sync
// R2 - Direction bit: set input, clear drive output
// R3 - Polarity bit: set active high, clear low
// R4 - Master auto select drives pin while transmitting
// R5 - Width bit: whole character or one clock
// R6 - Count field sets characters per sync pulse
// R7 - Clock source, deep buffer writable only while off
// R8 - Software clears clock edge bit in framed mode
// R9 - Audio mode forces clock idle polarity high
// R10 - Clear, set, invert aliases at 4, 8, C
// R11 - Registers reset zero, status resets to 0008
// R12 - Unimplemented bits read zero, ignore writes
// R13 - Serial pin disable bits are stored only
// R14 - Edge select: sync with or before first bit
// R15 - Clock source: reference tick or bus clock
// R16 - Reserved count codes act as one character

////////////////////////////////////////////////////////////////////////////////
`define SFS_P1_CON      16'h8080
`define SFS_P1_STAT     16'h8090
`define SFS_P1_BUF      16'h80a0
`define SFS_P1_BRG      16'h80b0
`define SFS_P1_CON2     16'h80c0
`define SFS_P2_CON      16'h8100
`define SFS_P2_STAT     16'h8110
`define SFS_P2_BUF      16'h8120
`define SFS_P2_BRG      16'h8130
`define SFS_P2_CON2     16'h8140

`define SFS_OP_WR       2'h0
`define SFS_OP_CLR      2'h1
`define SFS_OP_SET      2'h2
`define SFS_OP_INV      2'h3

////////////////////////////////////////////////////////////////////////////////
`define SFS_B_FRAMED    31
`define SFS_B_FDIR      30
`define SFS_B_FPOL      29
`define SFS_B_MSS       28
`define SFS_B_FWIDTH    27
`define SFS_F_FCNT      26:24
`define SFS_B_CLKSRC    23
`define SFS_B_FEDGE     17
`define SFS_B_DEEP      16
`define SFS_B_ON        15
`define SFS_B_M32       11
`define SFS_B_M16       10
`define SFS_B_CKE       8
`define SFS_B_CKP       6
`define SFS_B_MSTEN     5
`define SFS_B_AUDIO_PROTOCOL_ENABLE     7
`define SFS_B_ROV       6

`define SFS_CON_WMASK   32'hff83_bfff
`define SFS_CON_LOCK    32'h0081_0000
`define SFS_CON2_WMASK  32'h0000_9f8b
`define SFS_BRG_WMASK   32'h0000_1fff
`define SFS_STAT_WMASK  32'h0000_0040
`define SFS_REG_RST     32'h0000_0000
`define SFS_STAT_RST    32'h0000_0008

`define SFS_TX_DEPTH    8
`define SFS_TX_AW       3
`endif

// *** core/sfs_fifo.v ***
`timescale 1ns/1ps
// Storage words come out through a register so the array maps onto RAM.
module sfs_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk_i,        // System clock.
	input  wire             rst_i,        // Synchronous reset.
	input  wire [WIDTH-1:0] in_data_i,    // Write word.
	input  wire             in_valid_i,   // Write request.
	output wire             in_ready_o,   // Room for one more word.
	output wire [WIDTH-1:0] out_data_o,   // Head word.
	output wire             out_valid_o,  // Head word present.
	input  wire             out_ready_i,  // Head word taken.
	output wire [AW:0]      level_o       // Words held.
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp_ff;
	reg [AW-1:0]    rp_ff;
	reg [AW:0]      mc_ff;
	reg             ov_ff;
	reg [WIDTH-1:0] od_ff;
	wire [AW:0]     lvl  = mc_ff + {{AW{1'b0}}, ov_ff};
	wire            push = in_valid_i & in_ready_o;
	wire            load = (mc_ff != {(AW+1){1'b0}}) & (~ov_ff | out_ready_i);

	assign in_ready_o  = (lvl < DEPTH);
	assign out_data_o  = od_ff;
	assign out_valid_o = ov_ff;
	assign level_o     = lvl;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			mc_ff <= {(AW+1){1'b0}};
			ov_ff <= 1'b0;
			od_ff <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem[wp_ff] <= in_data_i;
				wp_ff      <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			if (load) begin
				od_ff <= mem[rp_ff];
				rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			ov_ff <= load | (ov_ff & ~out_ready_i);
			mc_ff <= mc_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
		end
	end
endmodule

// *** core/sfs_baud.v ***
`timescale 1ns/1ps
// One tick per half bit clock: source rate divided by divisor plus one.
module sfs_baud #(
	parameter DW = 13
) (
	input  wire          clk_i,   // System clock.
	input  wire          rst_i,   // Synchronous reset.
	input  wire          en_i,    // Generator running.
	input  wire          src_i,   // Source rate enable.
	input  wire [DW-1:0] div_i,   // Divisor value.
	output wire          tick_o   // Half period pulse.
);
	reg [DW-1:0] cnt_ff;
	reg          tick_ff;

	assign tick_o = tick_ff;

	always @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt_ff  <= {DW{1'b0}};
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (src_i) begin
				if (cnt_ff == div_i) begin
					cnt_ff  <= {DW{1'b0}};
					tick_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + {{(DW-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// *** core/sfs_top.v ***
`timescale 1ns/1ps
`include "sfs_defines.vh"
module sfs_top (
	input  wire        clk_i,       // System clock, 100 MHz.
	input  wire        rst_i,       // Synchronous reset, active high.
	input  wire        wb_cyc_i,    // Bus cycle.
	input  wire        wb_stb_i,    // Bus strobe.
	input  wire        wb_we_i,     // Bus write.
	input  wire [15:0] wb_adr_i,    // Byte address.
	input  wire [3:0]  wb_sel_i,    // Byte lanes.
	input  wire [31:0] wb_dat_i,    // Write data.
	output wire [31:0] wb_dat_o,    // Read data.
	output wire        wb_ack_o,    // Acknowledge.
	input  wire        ref_tick_i,  // Reference clock output as enable pulse.
	output wire [1:0]  sck_o,       // Serial clock per port.
	output wire [1:0]  sdo_o,       // Serial data out per port.
	input  wire [1:0]  sdi_i,       // Serial data in per port.
	output wire [1:0]  sel_o,       // Select or frame pulse out.
	output wire [1:0]  sel_oe_o,    // Select pin driven.
	input  wire [1:0]  sel_i        // Select or frame pulse in.
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_SYNC  = 2'd1;
	localparam ST_BIT   = 2'd2;
	localparam ST_WAITF = 2'd3;

	////////////////////////////////////////////////////////////////////////////////
	// Returns hit, port, register index and alias operation.
	function [6:0] dec;
		input [15:0] a;
		reg   [2:0]  r;
		reg          h;
		reg          p;
		begin
			r = 3'd0;
			h = 1'b1;
			p = 1'b0;
			case ({a[15:4], 4'h0})
				`SFS_P1_CON:  r = 3'd0;
				`SFS_P1_STAT: r = 3'd1;
				`SFS_P1_BUF:  r = 3'd2;
				`SFS_P1_BRG:  r = 3'd3;
				`SFS_P1_CON2: r = 3'd4;
				`SFS_P2_CON: begin
					r = 3'd0;
					p = 1'b1;
				end
				`SFS_P2_STAT: begin
					r = 3'd1;
					p = 1'b1;
				end
				`SFS_P2_BUF: begin
					r = 3'd2;
					p = 1'b1;
				end
				`SFS_P2_BRG: begin
					r = 3'd3;
					p = 1'b1;
				end
				`SFS_P2_CON2: begin
					r = 3'd4;
					p = 1'b1;
				end
				default: h = 1'b0;
			endcase
			if (a[1:0] != 2'b00)
				h = 1'b0;
			if (r == 3'd2 && a[3:2] != `SFS_OP_WR)
				h = 1'b0; // see R10
			dec = {h, p, r, a[3:2]};
		end
	endfunction

	// Bits outside the write mask keep their value, so reserved bits stay zero.
	function [31:0] upd;
		input [31:0] old;
		input [31:0] d;
		input [31:0] bm;
		input [1:0]  op;
		input [31:0] m;
		reg   [31:0] v;
		begin
			case (op)
				`SFS_OP_WR:  v = (old & ~bm) | (d & bm);
				`SFS_OP_CLR: v = old & ~(d & bm); // see R10
				`SFS_OP_SET: v = old | (d & bm); // see R10
				default:     v = old ^ (d & bm); // see R10
			endcase
			upd = (v & m) | (old & ~m); // see R12
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	reg         ack_ff;
	reg  [31:0] dat_ff;
	wire [63:0] rd_w;
	wire [6:0]  d   = dec(wb_adr_i);
	wire [31:0] bm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        acc = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire        wr  = acc & wb_we_i & d[6];
	wire        rd  = acc & ~wb_we_i & d[6];

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// Unmapped addresses are acknowledged and read as zero; alias reads are zero too.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= `SFS_REG_RST;
		end else begin
			ack_ff <= acc;
			dat_ff <= `SFS_REG_RST;
			if (rd && d[1:0] == `SFS_OP_WR)
				dat_ff <= rd_w[{d[5], 5'd0} +: 32];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : prt
			reg  [31:0] con_ff;
			reg  [31:0] con2_ff;
			reg  [12:0] brg_ff;
			reg  [31:0] rx_ff;
			reg         rbf_ff;
			reg         rov_ff;
			reg  [2:0]  sdi_s_ff;
			reg  [2:0]  sel_s_ff;
			reg         sdi_f_ff;
			reg         sel_f_ff;
			reg  [1:0]  st_ff;
			reg         half_ff;
			reg  [5:0]  bit_ff;
			reg  [4:0]  chr_ff;
			reg  [31:0] sh_ff;
			reg  [31:0] rxs_ff;
			reg         fs_ff;
			reg         done_ff;
			reg         sck_ff;
			reg         sdo_ff;
			reg         sel_ff;
			reg         seloe_ff;
			wire        me     = (d[5] == (g == 1));
			wire        w_con  = wr & me & (d[4:2] == 3'd0);
			wire        w_stat = wr & me & (d[4:2] == 3'd1);
			wire        w_buf  = wr & me & (d[4:2] == 3'd2);
			wire        w_brg  = wr & me & (d[4:2] == 3'd3);
			wire        w_con2 = wr & me & (d[4:2] == 3'd4);
			wire        pop_rx = rd & me & (d[4:2] == 3'd2) & (d[1:0] == `SFS_OP_WR);
			wire        on     = con_ff[`SFS_B_ON];
			wire        run    = on & con_ff[`SFS_B_MSTEN];
			wire        framed = con_ff[`SFS_B_FRAMED]; // see R1
			wire        fdir   = con_ff[`SFS_B_FDIR];
			wire        fpol   = con_ff[`SFS_B_FPOL];
			wire        fwid   = con_ff[`SFS_B_FWIDTH];
			wire        fedge  = con_ff[`SFS_B_FEDGE];
			wire        idle   = con_ff[`SFS_B_CKP] | con2_ff[`SFS_B_AUDIO_PROTOCOL_ENABLE]; // see R9
			wire        ecke   = con_ff[`SFS_B_CKE] & ~framed; // see R8
			wire [2:0]  fcnt   = con_ff[`SFS_F_FCNT];
			wire [5:0]  grp    = (fcnt > 3'd5) ? 6'd1 : (6'd1 << fcnt); // see R6, R16
			wire [5:0]  last   = grp - 6'd1;
			wire [5:0]  wlen   = con_ff[`SFS_B_M32] ? 6'd32 :
			                     con_ff[`SFS_B_M16] ? 6'd16 : 6'd8;
			wire [5:0]  sham   = 6'd32 - wlen;
			wire        fs_in  = (sel_f_ff == fpol); // see R2, R3
			wire        tick;
			wire [31:0] f_dat;
			wire        f_val;
			wire        f_rdy;
			wire [3:0]  f_lvl;
			wire        pop_tx = run & (st_ff == ST_IDLE) & f_val;
			wire [31:0] ld     = f_dat << sham;
			wire        busy   = (st_ff != ST_IDLE);
			// A shallow buffer holds one word until the shifter takes it.
			wire        tbf    = ~f_rdy | (~con_ff[`SFS_B_DEEP] & (f_lvl != 4'd0));
			wire [31:0] stat_v = {11'h000, 1'b0, f_lvl, 4'h0, busy, 4'h0, rov_ff,
			                      2'b00, (f_lvl == 4'd0), 1'b0, tbf, rbf_ff};
			wire [31:0] stat_w = upd(stat_v, wb_dat_i, bm, d[1:0], `SFS_STAT_WMASK);
			wire [31:0] con_m  = on ? (`SFS_CON_WMASK & ~`SFS_CON_LOCK) : `SFS_CON_WMASK;
			wire [31:0] brg_w  = upd({19'h0_0000, brg_ff}, wb_dat_i, bm, d[1:0], `SFS_BRG_WMASK);

			sfs_fifo #(
				.WIDTH (32),
				.DEPTH (`SFS_TX_DEPTH),
				.AW    (`SFS_TX_AW)
			) u_txq (
				.clk_i       (clk_i),
				.rst_i       (rst_i),
				.in_data_i   (wb_dat_i & bm),
				.in_valid_i  (w_buf & ~tbf),
				.in_ready_o  (f_rdy),
				.out_data_o  (f_dat),
				.out_valid_o (f_val),
				.out_ready_i (pop_tx),
				.level_o     (f_lvl)
			);

			sfs_baud #(
				.DW (13)
			) u_baud (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.en_i   (run),
				.src_i  (con_ff[`SFS_B_CLKSRC] ? ref_tick_i : 1'b1), // see R15
				.div_i  (brg_ff),
				.tick_o (tick)
			);

			// The pin disable bits are kept as storage only; pin routing is elsewhere.
			always @(posedge clk_i) begin
				if (rst_i) begin
					con_ff  <= `SFS_REG_RST; // see R11
					con2_ff <= `SFS_REG_RST; // see R11
					brg_ff  <= 13'h0000; // see R11
				end else begin
					if (w_con)
						con_ff <= upd(con_ff, wb_dat_i, bm, d[1:0], con_m); // see R7, R13
					if (w_con2)
						con2_ff <= upd(con2_ff, wb_dat_i, bm, d[1:0], `SFS_CON2_WMASK);
					if (w_brg)
						brg_ff <= brg_w[12:0];
				end
			end

			// A character that completes while software clears the overflow flag still sets it.
			always @(posedge clk_i) begin
				if (rst_i) begin
					rx_ff  <= `SFS_REG_RST; // see R11
					rbf_ff <= 1'b0;
					rov_ff <= 1'b0;
				end else begin
					if (done_ff && (!rbf_ff || pop_rx)) begin
						rx_ff  <= rxs_ff;
						rbf_ff <= 1'b1;
					end else if (pop_rx) begin
						rbf_ff <= 1'b0;
					end
					rov_ff <= (done_ff & rbf_ff & ~pop_rx) |
					          (w_stat ? stat_w[`SFS_B_ROV] : rov_ff);
				end
			end

			// Pin inputs are filtered: a change counts once two late stages agree.
			always @(posedge clk_i) begin
				if (rst_i) begin
					sdi_s_ff <= 3'h0;
					sel_s_ff <= 3'h0;
					sdi_f_ff <= 1'b0;
					sel_f_ff <= 1'b0;
				end else begin
					sdi_s_ff <= {sdi_s_ff[1:0], sdi_i[g]};
					sel_s_ff <= {sel_s_ff[1:0], sel_i[g]};
					if (sdi_s_ff[2] == sdi_s_ff[1])
						sdi_f_ff <= sdi_s_ff[1];
					if (sel_s_ff[2] == sel_s_ff[1])
						sel_f_ff <= sel_s_ff[1];
				end
			end

			////////////////////////////////////////////////////////////////////////
			always @(posedge clk_i) begin
				if (rst_i || !run) begin
					st_ff   <= ST_IDLE;
					half_ff <= 1'b0;
					bit_ff  <= 6'd0;
					chr_ff  <= 5'd0;
					sh_ff   <= 32'h0000_0000;
					rxs_ff  <= 32'h0000_0000;
					fs_ff   <= 1'b0;
					done_ff <= 1'b0;
					sck_ff  <= rst_i ? 1'b0 : idle;
					sdo_ff  <= 1'b0;
				end else begin
					done_ff <= 1'b0;
					case (st_ff)
						ST_IDLE: begin
							sck_ff <= idle; // see R9
							if (f_val) begin
								sh_ff   <= ld;
								sdo_ff  <= ld[31];
								rxs_ff  <= 32'h0000_0000;
								bit_ff  <= 6'd0;
								half_ff <= 1'b0;
								if (framed && chr_ff == 5'd0) begin
									if (fdir) begin
										st_ff <= ST_WAITF; // see R2
									end else begin
										fs_ff <= 1'b1; // see R1
										st_ff <= fedge ? ST_BIT : ST_SYNC; // see R14
									end
								end else begin
									st_ff <= ST_BIT;
								end
							end
						end
						ST_WAITF: begin
							if (fs_in)
								st_ff <= ST_BIT; // see R2
						end
						ST_SYNC: begin
							if (tick) begin
								half_ff <= ~half_ff;
								if (half_ff) begin
									st_ff <= ST_BIT; // see R14
									if (!fwid)
										fs_ff <= 1'b0; // see R5
								end
							end
						end
						ST_BIT: begin
							if (tick) begin
								sck_ff  <= ~sck_ff;
								half_ff <= ~half_ff;
								if (half_ff == ~ecke)
									rxs_ff <= {rxs_ff[30:0], sdi_f_ff};
								if (half_ff) begin
									if ((!fwid && bit_ff == 6'd0) || (fwid && !fedge && bit_ff == wlen - 6'd2))
										fs_ff <= 1'b0; // see R5, R14
									if (bit_ff == wlen - 6'd1) begin
										st_ff   <= ST_IDLE;
										done_ff <= 1'b1;
										fs_ff   <= 1'b0; // see R5
										chr_ff  <= (framed && chr_ff != last[4:0]) ?
										           chr_ff + 5'd1 : 5'd0; // see R6
									end else begin
										bit_ff <= bit_ff + 6'd1;
										sh_ff  <= sh_ff << 1;
										sdo_ff <= sh_ff[30];
									end
								end
							end
						end
						default: st_ff <= ST_IDLE;
					endcase
				end
			end

			always @(posedge clk_i) begin
				if (rst_i) begin
					sel_ff   <= 1'b0;
					seloe_ff <= 1'b0;
				end else if (on && framed) begin
					seloe_ff <= ~fdir; // see R1, R2
					sel_ff   <= fpol ? fs_ff : ~fs_ff; // see R3
				end else if (run && con_ff[`SFS_B_MSS]) begin
					seloe_ff <= 1'b1; // see R4
					sel_ff   <= fpol ? (busy | pop_tx) : ~(busy | pop_tx); // see R4
				end else begin
					seloe_ff <= 1'b0; // see R4
					sel_ff   <= 1'b0;
				end
			end

			assign rd_w[g*32 +: 32] = (d[4:2] == 3'd0) ? con_ff :
			                          (d[4:2] == 3'd1) ? stat_v :
			                          (d[4:2] == 3'd2) ? rx_ff :
			                          (d[4:2] == 3'd3) ? {19'h0_0000, brg_ff} : con2_ff;
			assign sck_o[g]    = sck_ff;
			assign sdo_o[g]    = sdo_ff;
			assign sel_o[g]    = sel_ff;
			assign sel_oe_o[g] = seloe_ff;
		end
	endgenerate
endmodule

// *** tb/sfs_top_sva.sv ***
`timescale 1ns/1ps
`include "sfs_defines.vh"
module sfs_top_sva (
	input wire        clk_i,     // System clock.
	input wire        rst_i,     // Synchronous reset.
	input wire        wb_cyc_i,  // Bus cycle.
	input wire        wb_stb_i,  // Bus strobe.
	input wire        wb_we_i,   // Bus write.
	input wire [15:0] wb_adr_i,  // Byte address.
	input wire [3:0]  wb_sel_i,  // Byte lanes.
	input wire [31:0] wb_dat_i,  // Write data.
	input wire [31:0] wb_dat_o,  // Read data.
	input wire        wb_ack_o,  // Acknowledge.
	input wire [1:0]  sck_o,     // Serial clocks.
	input wire [1:0]  sel_oe_o   // Select pins driven.
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [31:0] con_ff;
	logic        ok_ff;
	logic [2:0]  age_ff;
	// Port one control is shadowed from plain full-word writes only; an alias or
	// partial write leaves the shadow untrusted rather than modelling it twice.
	always @(posedge clk_i) begin
		if (rst_i) begin
			con_ff <= 32'h0000_0000;
			ok_ff  <= 1'b1;
			age_ff <= 3'h0;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i[15:4] == 12'h808) begin
			con_ff <= wb_dat_i;
			ok_ff  <= (wb_adr_i[3:0] == 4'h0) && (wb_sel_i == 4'hf);
			age_ff <= 3'h0;
		end else if (age_ff != 3'h7) begin
			age_ff <= age_ff + 3'h1;
		end
	end
	ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("acknowledge without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside acknowledge");
	alias_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[3:0]) != 4'h0
		|-> wb_dat_o == 32'h0000_0000)
		else $error("alias read not zero");
	con_unimpl_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `SFS_P1_CON
		|-> (wb_dat_o & ~`SFS_CON_WMASK) == 32'h0000_0000)
		else $error("control unimplemented bits set");
	brg_unimpl_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `SFS_P2_BRG
		|-> wb_dat_o[31:13] == 19'h0)
		else $error("divider unimplemented bits set");
	sel_quiet_a: assert property (ok_ff && age_ff > 3'h3 && !con_ff[28] && (!con_ff[31] || con_ff[30])
		|-> !sel_oe_o[0])
		else $error("select pin driven while not owned");
	sel_drive_a: assert property (ok_ff && age_ff > 3'h3 && con_ff[28] && !con_ff[31] && con_ff[15]
		&& con_ff[5] |-> sel_oe_o[0])
		else $error("auto select not driven");
	frame_drive_a: assert property (ok_ff && age_ff > 3'h3 && con_ff[31] && !con_ff[30]
		&& con_ff[15] && con_ff[5] |-> sel_oe_o[0] [*2])
		else $error("frame pulse pin not driven");
endmodule
bind sfs_top sfs_top_sva i_sfs_top_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_o(sck_o),
	.sel_oe_o(sel_oe_o));

// *** tb/sfs_peer.sv ***
`timescale 1ns/1ps
module sfs_peer #(
	parameter logic [7:0] REPLY = 8'h3c
) (
	input  wire        clk_i,  // System clock for the idle pattern.
	input  wire        sck_i,  // Serial clock from the device.
	input  wire        sdo_i,  // Data from the device.
	input  wire        sel_i,  // Select level.
	input  wire        oe_i,   // Select driven.
	output wire        sdi_o,  // Data to the device.
	output logic [7:0] rx_o    // Character taken, first bit highest.
);
	logic [7:0] sh_ff;
	logic       tog_ff;
	initial begin
		sh_ff = REPLY;
		rx_o = 8'h00;
		tog_ff = 1'b0;
	end
	always @(posedge clk_i) tog_ff <= ~tog_ff;
	// Unselected, the line toggles so that a stale bit can never pass for data.
	assign sdi_o = (oe_i && sel_i) ? sh_ff[7] : tog_ff;
	// Data is taken on the leading clock edge, mid bit, and the reply moves on the trailing one.
	always @(posedge sck_i) begin
		if (oe_i && sel_i)
			rx_o <= {rx_o[6:0], sdo_i};
	end
	always @(negedge sck_i) begin
		if (oe_i && sel_i)
			sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
	end
endmodule

// *** tb/test_spi_frame_sync_control.sv ***
`timescale 1ns/1ps
`include "sfs_defines.vh"
module test_spi_frame_sync_control;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ref_tick_i, prev;
	logic [15:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [1:0]  fs_pin;
	logic [31:0] wb_dat_i, rdat;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o;
	wire  [1:0]  sck_o, sdo_o, sel_o, sel_oe_o, sdi_i;
	wire  [7:0]  peer_rx;
	int          errors, cmp_count, cycles, hi_n, pulses;
	logic [15:0] regs [10] = '{16'h8080, 16'h8090, 16'h80a0, 16'h80b0, 16'h80c0,
		16'h8100, 16'h8110, 16'h8120, 16'h8130, 16'h8140};
	sfs_top i_sfs_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_tick_i(ref_tick_i), .sck_o(sck_o),
		.sdo_o(sdo_o), .sdi_i(sdi_i), .sel_o(sel_o), .sel_oe_o(sel_oe_o), .sel_i(fs_pin));
	sfs_peer i_sfs_peer (.clk_i(clk_i), .sck_i(sck_o[0]), .sdo_i(sdo_o[0]), .sel_i(sel_o[0]),
		.oe_i(sel_oe_o[0]), .sdi_o(sdi_i[0]), .rx_o(peer_rx));
	assign sdi_i[1] = 1'b0;
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Pulse monitor counts driven high cycles and rising edges of port one's select pin.
	always @(posedge clk_i) begin
		cycles++;
		ref_tick_i <= (cycles % 4 == 0);
		if (sel_o[0] && sel_oe_o[0]) hi_n++;
		if (sel_o[0] && sel_oe_o[0] && !prev) pulses++;
		prev <= sel_o[0] & sel_oe_o[0];
		if (cycles == 20000) begin
			errors++;
			$display("ERROR %0t ns: run out of time", $time);
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compares %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t ns: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask
	task automatic wait_idle();
		rdat = 32'h0000_0800;
		while (rdat[11] || !rdat[3]) bus(1'b0, `SFS_P1_STAT, 32'h0000_0000);
		repeat (4) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ref_tick_i, prev} = 6'b100000;
		{wb_adr_i, wb_sel_i, wb_dat_i} = 52'h0;
		fs_pin = 2'b00;
		{errors, cmp_count, cycles, hi_n, pulses} = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk({24'h0, sck_o, sdo_o, sel_o, sel_oe_o}, 32'h0000_0000);
		foreach (regs[i]) rd(regs[i], regs[i][3:0] == 4'h0 && regs[i][7:4] % 8 == 1 ?
			`SFS_STAT_RST : `SFS_REG_RST);
		$display("done: reset values");
		wr(`SFS_P1_CON, 32'hffff_ffff);
		rd(`SFS_P1_CON, `SFS_CON_WMASK);
		wr(`SFS_P1_BRG, 32'hffff_ffff);
		rd(`SFS_P1_BRG, `SFS_BRG_WMASK);
		wr(`SFS_P2_BRG, 32'hffff_ffff);
		rd(`SFS_P2_BRG, `SFS_BRG_WMASK);
		wr(`SFS_P1_CON, 32'h0000_0000);
		rd(`SFS_P1_CON, `SFS_CON_LOCK);
		wr(`SFS_P1_CON, 32'h0000_0000);
		rd(`SFS_P1_CON, 32'h0000_0000);
		$display("done: access and lock");
		wr(16'h80c8, 32'h0000_0083);
		rd(`SFS_P1_CON2, 32'h0000_0083);
		wr(16'h80c4, 32'h0000_0001);
		rd(`SFS_P1_CON2, 32'h0000_0082);
		wr(16'h80cc, 32'h0000_0009);
		rd(`SFS_P1_CON2, 32'h0000_008b);
		rd(16'h80c4, 32'h0000_0000);
		wr(16'h80a4, 32'h0000_00ff);
		rd(`SFS_P1_BUF, 32'h0000_0000);
		rd(16'h8000, 32'h0000_0000);
		$display("done: aliases");
		wr(`SFS_P1_BRG, 32'h0000_0000);
		wr(`SFS_P1_CON, 32'h0000_8020);
		repeat (4) @(posedge clk_i);
		chk({31'h0, sck_o[0]}, 32'h0000_0001);
		wr(16'h80c4, 32'h0000_0080);
		repeat (4) @(posedge clk_i);
		chk({31'h0, sck_o[0]}, 32'h0000_0000);
		$display("done: audio idle level");
		wr(`SFS_P1_CON, 32'h0000_0000);
		wr(`SFS_P1_BRG, 32'h0000_0007);
		wr(`SFS_P1_CON, 32'h3000_8020);
		pulses = 0;
		wr(`SFS_P1_BUF, 32'h0000_00a5);
		wait_idle();
		chk(pulses, 1);
		chk({31'h0, sel_o[0]}, 32'h0000_0000);
		chk({24'h0, peer_rx}, 32'h0000_00a5);
		rd(`SFS_P1_BUF, 32'h0000_003c);
		$display("done: auto select");
		wr(`SFS_P1_CON, 32'h0000_0000);
		wr(`SFS_P1_BRG, 32'h0000_0000);
		wr(`SFS_P1_CON, 32'ha801_8020);
		hi_n = 0;
		wr(`SFS_P1_BUF, 32'h0000_005a);
		wait_idle();
		chk(hi_n, 16);
		for (int c = 0; c < 3; c++) begin
			wr(`SFS_P1_CON, 32'h0000_0000);
			wr(`SFS_P1_CON, 32'ha001_8020 | (c << 24) | ((c & 1) << 17));
			hi_n = 0;
			pulses = 0;
			repeat (4) wr(`SFS_P1_BUF, c);
			wait_idle();
			chk(pulses, 4 >> c);
			chk(hi_n, 2 * (4 >> c));
		end
		$display("done: framed pulses");
		wr(`SFS_P1_CON, 32'h0000_0000);
		wr(`SFS_P1_CON, 32'he001_8020);
		wr(`SFS_P1_BUF, 32'h0000_0077);
		repeat (40) @(posedge clk_i);
		bus(1'b0, `SFS_P1_STAT, 32'h0000_0000);
		chk(rdat & 32'h0000_0800, 32'h0000_0800);
		chk({31'h0, sel_oe_o[0]}, 32'h0000_0000);
		fs_pin <= 2'b01;
		wait_idle();
		fs_pin <= 2'b00;
		$display("done: framed slave");
		end_sim();
	end
endmodule
